// ### shared/vcci_pkg.sv
package vcci_pkg;

  // ----------------------------------------------------------------
  // line numbers and clock
  // ----------------------------------------------------------------
  localparam logic [9:0] CC_ODD_LINE    = 10'h015;  // line 21
  localparam logic [9:0] CC_EVEN_LINE   = 10'h11c;  // line 284
  localparam logic [9:0] COPY_ODD_LINE  = 10'h014;  // line 20
  localparam logic [9:0] COPY_EVEN_LINE = 10'h11b;  // line 283
  localparam int         CLK_MHZ        = 125;

  // ----------------------------------------------------------------
  // symbol counts of each waveform
  // ----------------------------------------------------------------
  localparam logic [3:0] CC_RUNIN_CYCLES = 4'h7;
  localparam logic [5:0] CC_SYMBOLS      = 6'h1a;   // 7 run-in + 2 blank + start + 16 data
  localparam logic [3:0] COPY_RUNIN      = 4'h0;
  localparam logic [5:0] COPY_SYMBOLS    = 6'h15;   // reference pulse + 20 bits
  localparam logic [5:0] CRC_PRESET      = 6'h3f;
  localparam logic [5:0] CRC_TAPS        = 6'h03;   // x^6 + x + 1

  // ----------------------------------------------------------------
  // register byte addresses and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_CC_ODD0  = 8'h04;
  localparam logic [7:0] ADDR_CC_ODD1  = 8'h08;
  localparam logic [7:0] ADDR_CC_EVEN0 = 8'h0c;
  localparam logic [7:0] ADDR_CC_EVEN1 = 8'h10;
  localparam logic [7:0] ADDR_COPY0    = 8'h14;
  localparam logic [7:0] ADDR_COPY1    = 8'h18;
  localparam logic [7:0] ADDR_COPY2    = 8'h1c;
  localparam logic [7:0] ADDR_STATUS   = 8'h20;
  localparam int BIT_NTSC     = 0;
  localparam int BIT_CC_ODD   = 1;
  localparam int BIT_CC_EVEN  = 2;
  localparam int BIT_CRC_AUTO = 4;  // in copy_info_reg0
  localparam int BIT_COPY_ODD = 5;
  localparam int BIT_COPY_EVN = 6;
  localparam logic [7:0] CTRL_RESET = 8'h07;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : vcci_pkg

// ### rtl/vcci_symbol_shifter.sv
`timescale 1ns/1ps
module vcci_symbol_shifter
  import vcci_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [3:0]  runInCount,
  input  wire logic [5:0]  symbolCount,
  input  wire logic [31:0] frameBits,
  input  wire logic [15:0] bitCycles,
  output logic             busy,
  output logic             level,
  output logic             runIn
);

  // ----------------------------------------------------------------
  // symbol state
  // ----------------------------------------------------------------
  logic [31:0] shiftReg;
  logic [5:0]  symLeft;
  logic [3:0]  runLeft;
  logic [15:0] cyc;

  wire bitEnd   = (cyc == bitCycles - 16'h0001);
  wire firstHalf = (cyc < {1'b0, bitCycles[15:1]});

  // run-in is one square cycle per bit period, locked to the bit clock
  assign runIn = busy && (runLeft != 4'h0);
  assign level = busy && (runIn ? firstHalf : shiftReg[0]);

  // start reloads even if busy; lines never overlap in practice
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy     <= 1'b0;
      shiftReg <= 32'h0000_0000;
      symLeft  <= 6'h00;
      runLeft  <= 4'h0;
      cyc      <= 16'h0000;
    end else if (start) begin
      busy     <= 1'b1;
      shiftReg <= frameBits;
      symLeft  <= symbolCount;
      runLeft  <= runInCount;
      cyc      <= 16'h0000;
    end else if (busy) begin
      cyc <= bitEnd ? 16'h0000 : cyc + 16'h0001;
      if (bitEnd) begin
        if (runLeft != 4'h0) runLeft <= runLeft - 4'h1;
        else shiftReg <= {1'b0, shiftReg[31:1]};  // lsb first
        symLeft <= symLeft - 6'h01;
        if (symLeft == 6'h01) busy <= 1'b0;
      end
    end
  end

endmodule : vcci_symbol_shifter

// ### rtl/vcci_inserter.sv
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - caption data goes out on odd line 21 and even line 284
// - each caption line opens with seven run-in cycles locked to bit timing
// - run-in is followed by two blank bit periods and a one start bit
// - sixteen data bits follow as two bytes, seven data plus odd parity
// - odd-field caption bytes come from caption data registers 0 and 1
// - even line 284 carries extended caption bytes from the extended registers
// - caption timing is internal and pixel input is ignored on caption lines
// - caption registers are single buffered; new data goes on the next caption line
// - copy-generation data goes out on odd line 20 and even line 283
// - separate odd and even enables gate copy-generation output
// - copy-generation data is sent only in NTSC, never in PAL
// - the 20-bit copy word is preceded by a one-bit-wide reference pulse
// - C0-C7 from reg2, C8-C15 from reg1, C16-C19 from reg0 bits 0-3
// - with crc enabled, C14-C19 are a 6-bit CRC over C0-C13
// - CRC polynomial x^6+x+1, shift register preset to all ones
// - with crc disabled all twenty register bits go out unchanged
module vcci_inserter
  import vcci_pkg::*;
#(
  parameter int  CC_BIT_NS     = 1986,
  parameter int  COPY_BIT_NS   = 2235,
  parameter int  CC_START_NS   = 10500,
  parameter int  COPY_START_NS = 11200,
  parameter logic [7:0] BLANK_CODE = 8'h10,
  parameter logic [7:0] HIGH_CODE  = 8'h7e
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  // video timing generator, same clock
  input  wire logic        lineStart,
  input  wire logic [9:0]  lineNumber,
  input  wire logic        oddField,
  input  wire logic [7:0]  pixelIn,
  output logic      [7:0]  pixelOut,
  output logic             vbiInsert,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // timing counts, rounded down so a bit never runs long
  // ----------------------------------------------------------------
  localparam logic [15:0] CC_BIT_CYC     = 16'((CC_BIT_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] COPY_BIT_CYC   = 16'((COPY_BIT_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] CC_START_CYC   = 16'((CC_START_NS * CLK_MHZ) / 1000);
  localparam logic [15:0] COPY_START_CYC = 16'((COPY_START_NS * CLK_MHZ) / 1000);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] ccOdd0, ccOdd1, ccEven0, ccEven1;
  logic [7:0] copy_info_reg0, copy_info_reg1, copy_info_reg2;

  // ----------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------
  logic       awHeld, wHeld;
  logic [7:0] awAddr;
  logic [7:0] wByte;
  logic       wLane0;

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;

  wire awTake   = s_axi_awvalid && s_axi_awready;
  wire wTake    = s_axi_wvalid && s_axi_wready;
  wire awNow    = awHeld || awTake;
  wire wNow     = wHeld || wTake;
  wire [7:0] wrAddr = awHeld ? awAddr : s_axi_awaddr;
  wire [7:0] wrData = wHeld ? wByte : s_axi_wdata[7:0];
  wire       wrLane = wHeld ? wLane0 : s_axi_wstrb[0];
  wire doWrite  = awNow && wNow && !s_axi_bvalid;

  // write decode
  wire wrCtrl  = doWrite && wrLane && (wrAddr == ADDR_CTRL);
  wire wrOdd0  = doWrite && wrLane && (wrAddr == ADDR_CC_ODD0);
  wire wrOdd1  = doWrite && wrLane && (wrAddr == ADDR_CC_ODD1);
  wire wrEven0 = doWrite && wrLane && (wrAddr == ADDR_CC_EVEN0);
  wire wrEven1 = doWrite && wrLane && (wrAddr == ADDR_CC_EVEN1);
  wire wrCopy0 = doWrite && wrLane && (wrAddr == ADDR_COPY0);
  wire wrCopy1 = doWrite && wrLane && (wrAddr == ADDR_COPY1);
  wire wrCopy2 = doWrite && wrLane && (wrAddr == ADDR_COPY2);
  wire wrMapped = (wrAddr == ADDR_CTRL) || (wrAddr == ADDR_CC_ODD0) || (wrAddr == ADDR_CC_ODD1)
               || (wrAddr == ADDR_CC_EVEN0) || (wrAddr == ADDR_CC_EVEN1) || (wrAddr == ADDR_COPY0)
               || (wrAddr == ADDR_COPY1) || (wrAddr == ADDR_COPY2) || (wrAddr == ADDR_STATUS);

  // hold whichever half arrived first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 8'h00;
      wByte  <= 8'h00;
      wLane0 <= 1'b0;
    end else begin
      awHeld <= awNow && !doWrite;
      wHeld  <= wNow && !doWrite;
      if (awTake) awAddr <= s_axi_awaddr;
      if (wTake) begin
        wByte  <= s_axi_wdata[7:0];
        wLane0 <= s_axi_wstrb[0];
      end
    end
  end

  // write response one cycle after both halves are in
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register storage, one byte each; no shadow copy so the next line uses it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl           <= CTRL_RESET;
      ccOdd0         <= 8'h00;
      ccOdd1         <= 8'h00;
      ccEven0        <= 8'h00;
      ccEven1        <= 8'h00;
      copy_info_reg0 <= 8'h00;
      copy_info_reg1 <= 8'h00;
      copy_info_reg2 <= 8'h00;
    end else begin
      if (wrCtrl) ctrl <= wrData;
      if (wrOdd0) ccOdd0 <= wrData;
      if (wrOdd1) ccOdd1 <= wrData;
      if (wrEven0) ccEven0 <= wrData;
      if (wrEven1) ccEven1 <= wrData;
      if (wrCopy0) copy_info_reg0 <= wrData;
      if (wrCopy1) copy_info_reg1 <= wrData;
      if (wrCopy2) copy_info_reg2 <= wrData;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic ccBusy, copyBusy, vbiLine;
  logic [7:0] rdByte;
  logic       rdMapped;

  assign s_axi_arready = !s_axi_rvalid;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire [7:0] statusByte = {4'h0, vbiLine, oddField, copyBusy, ccBusy};

  // read mux
  always_comb begin
    rdMapped = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL:     rdByte = ctrl;
      ADDR_CC_ODD0:  rdByte = ccOdd0;
      ADDR_CC_ODD1:  rdByte = ccOdd1;
      ADDR_CC_EVEN0: rdByte = ccEven0;
      ADDR_CC_EVEN1: rdByte = ccEven1;
      ADDR_COPY0:    rdByte = copy_info_reg0;
      ADDR_COPY1:    rdByte = copy_info_reg1;
      ADDR_COPY2:    rdByte = copy_info_reg2;
      ADDR_STATUS:   rdByte = statusByte;
      default: begin
        rdByte   = 8'h00;
        rdMapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (arTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rdByte};
      s_axi_rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // line selection
  // ----------------------------------------------------------------
  wire ntsc       = ctrl[BIT_NTSC];
  wire ccOddLine  = oddField && (lineNumber == CC_ODD_LINE) && ctrl[BIT_CC_ODD];
  wire ccEvenLine = !oddField && (lineNumber == CC_EVEN_LINE) && ctrl[BIT_CC_EVEN];
  wire copyOdd    = oddField && (lineNumber == COPY_ODD_LINE) && copy_info_reg0[BIT_COPY_ODD];
  wire copyEven   = !oddField && (lineNumber == COPY_EVEN_LINE) && copy_info_reg0[BIT_COPY_EVN];
  wire ccLine     = ccOddLine || ccEvenLine;
  wire copyLine   = ntsc && (copyOdd || copyEven);

  // ----------------------------------------------------------------
  // caption frame: 2 blank, start, byte0, byte1, all lsb first
  // ----------------------------------------------------------------
  wire [7:0] ccLo   = oddField ? ccOdd0 : ccEven0;
  wire [7:0] ccHi   = oddField ? ccOdd1 : ccEven1;
  wire [7:0] byteLo = {~^ccLo[6:0], ccLo[6:0]};
  wire [7:0] byteHi = {~^ccHi[6:0], ccHi[6:0]};
  wire [31:0] ccFrame = {13'h0000, byteHi, byteLo, 1'b1, 2'b00};

  // ----------------------------------------------------------------
  // copy word assembly and crc
  // ----------------------------------------------------------------
  wire [19:0] copyRaw = {copy_info_reg0[3:0], copy_info_reg1, copy_info_reg2};

  // serial crc over C0..C13 in transmit order
  function automatic logic [5:0] copy_crc(input logic [13:0] d);
    logic [5:0] c;
    logic       fb;
    c = CRC_PRESET;
    for (int i = 0; i < 14; i++) begin
      fb = d[i] ^ c[5];
      c  = {c[4:0], 1'b0} ^ (fb ? CRC_TAPS : 6'h00);
    end
    return c;
  endfunction : copy_crc

  wire [5:0]  crcBits  = copy_crc(copyRaw[13:0]);
  wire [19:0] copyWord = copy_info_reg0[BIT_CRC_AUTO] ? {crcBits, copyRaw[13:0]}
                                                      : copyRaw;
  wire [31:0] copyFrame = {11'h000, copyWord, 1'b1};

  // ----------------------------------------------------------------
  // per-line sequencing: arm at line start, fire after the start delay
  // ----------------------------------------------------------------
  logic        armCc, armCopy;
  logic [15:0] delayCnt;

  wire fireCc   = armCc && (delayCnt == CC_START_CYC);
  wire fireCopy = armCopy && (delayCnt == COPY_START_CYC);

  // a new line start cancels anything still armed
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      armCc    <= 1'b0;
      armCopy  <= 1'b0;
      vbiLine  <= 1'b0;
      delayCnt <= 16'h0000;
    end else if (lineStart) begin
      armCc    <= ccLine;
      armCopy  <= copyLine;
      vbiLine  <= ccLine || copyLine;
      delayCnt <= 16'h0000;
    end else begin
      if (fireCc) armCc <= 1'b0;
      if (fireCopy) armCopy <= 1'b0;
      if (armCc || armCopy) delayCnt <= delayCnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // one shifter serves both waveforms; they never share a line
  // ----------------------------------------------------------------
  logic shLevel, shRunIn, shBusy;
  logic lastWasCc;

  wire        shStart  = fireCc || fireCopy;
  wire [3:0]  shRunCnt = fireCc ? CC_RUNIN_CYCLES : COPY_RUNIN;
  wire [5:0]  shSyms   = fireCc ? CC_SYMBOLS : COPY_SYMBOLS;
  wire [31:0] shFrame  = fireCc ? ccFrame : copyFrame;
  wire [15:0] shCycles = fireCc ? CC_BIT_CYC : COPY_BIT_CYC;

  vcci_symbol_shifter u_shifter (
    .clk         (clk),
    .rst         (rst),
    .start       (shStart),
    .runInCount  (shRunCnt),
    .symbolCount (shSyms),
    .frameBits   (shFrame),
    .bitCycles   (shCycles),
    .busy        (shBusy),
    .level       (shLevel),
    .runIn       ()
  );

  // which waveform the shifter is carrying, for status
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lastWasCc <= 1'b0;
    else if (shStart) lastWasCc <= fireCc;
  end

  assign ccBusy   = shBusy && lastWasCc;
  assign copyBusy = shBusy && !lastWasCc;

  // ----------------------------------------------------------------
  // output: whole inserted line is generated, pixels dropped
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pixelOut  <= BLANK_CODE;
      vbiInsert <= 1'b0;
    end else begin
      vbiInsert <= vbiLine;
      if (!vbiLine) pixelOut <= pixelIn;
      else pixelOut <= shLevel ? HIGH_CODE : BLANK_CODE;
    end
  end

endmodule : vcci_inserter

// ### sim/vcci_inserter_chk.sv
`timescale 1ns/1ps
// ------
// port checker for the inserter
// ------
module vcci_inserter_chk
  import vcci_pkg::*;
#(
  parameter logic [7:0] BLANK_CODE = 8'h10,
  parameter logic [7:0] HIGH_CODE  = 8'h7e
)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        lineStart,
  input wire logic [9:0]  lineNumber,
  input wire logic        oddField,
  input wire logic [7:0]  pixelIn,
  input wire logic [7:0]  pixelOut,
  input wire logic        vbiInsert,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid
);
  logic [7:0] ctrlShadow;
  logic [7:0] copyShadow;
  logic [7:0] addrHeld;
  logic [7:0] dataHeld;
  logic       strbHeld;
  logic       bvalidSeen;
  logic [1:0] upCnt;
  wire        commit    = s_axi_bvalid && !bvalidSeen && s_axi_bresp == RESP_OKAY && strbHeld;
  wire        vbiNumber = lineNumber == CC_ODD_LINE || lineNumber == CC_EVEN_LINE ||
                          lineNumber == COPY_ODD_LINE || lineNumber == COPY_EVEN_LINE;

  // halves of a write may land on different edges
  always_ff @(posedge clk) begin
    if (s_axi_awvalid && s_axi_awready) addrHeld <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) {strbHeld, dataHeld} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
  end

  // enables mirrored one edge late; harmless, lines never start that soon
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {ctrlShadow, copyShadow, bvalidSeen, upCnt} <= {CTRL_RESET, 8'h00, 1'b0, 2'h0};
    end else begin
      bvalidSeen <= s_axi_bvalid;
      if (upCnt != 2'h3) upCnt <= upCnt + 2'h1;
      if (commit && addrHeld == ADDR_CTRL) ctrlShadow <= dataHeld;
      if (commit && addrHeld == ADDR_COPY0) copyShadow <= dataHeld;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_cc_odd; lineStart && lineNumber == CC_ODD_LINE && oddField && ctrlShadow[BIT_CC_ODD] |-> ##2 vbiInsert; endproperty
  a_cc_odd: assert property (p_cc_odd) else $error("caption line not inserted");
  property p_cc_field; lineStart && lineNumber == CC_ODD_LINE && !oddField |-> ##2 !vbiInsert; endproperty
  a_cc_field: assert property (p_cc_field) else $error("caption line in wrong field");
  property p_copy_on; lineStart && lineNumber == COPY_EVEN_LINE && !oddField && ctrlShadow[BIT_NTSC] &&
    copyShadow[BIT_COPY_EVN] |-> ##2 vbiInsert; endproperty
  a_copy_on: assert property (p_copy_on) else $error("copy line not inserted");
  property p_copy_gate; lineStart && lineNumber == COPY_ODD_LINE && !copyShadow[BIT_COPY_ODD] |-> ##2 !vbiInsert; endproperty
  a_copy_gate: assert property (p_copy_gate) else $error("copy line sent while disabled");
  property p_copy_pal; lineStart && (lineNumber == COPY_ODD_LINE || lineNumber == COPY_EVEN_LINE) &&
    !ctrlShadow[BIT_NTSC] |-> ##2 !vbiInsert; endproperty
  a_copy_pal: assert property (p_copy_pal) else $error("copy line sent outside ntsc");
  property p_other; lineStart && !vbiNumber |-> ##2 !vbiInsert; endproperty
  a_other: assert property (p_other) else $error("insert on an ordinary line");
  property p_span; $fell(vbiInsert) |-> $past(lineStart) || $past(lineStart, 2); endproperty
  a_span: assert property (p_span) else $error("insert ended inside a line");
  property p_levels; vbiInsert && $past(vbiInsert) |-> pixelOut == HIGH_CODE || pixelOut == BLANK_CODE; endproperty
  a_levels: assert property (p_levels) else $error("pixel data leaked into inserted line");
  property p_pass; upCnt == 2'h3 && !vbiInsert && !$past(vbiInsert) |-> pixelOut == $past(pixelIn); endproperty
  a_pass: assert property (p_pass) else $error("ordinary line not passed through");
endmodule : vcci_inserter_chk

bind vcci_inserter vcci_inserter_chk #(.BLANK_CODE(BLANK_CODE), .HIGH_CODE(HIGH_CODE)) chk (.*);

// ### sim/vcci_host_model.sv
`timescale 1ns/1ps
// ------
// host processor on the register bus
// ------
module vcci_host_model
  import vcci_pkg::*;
(
  input  wire logic        clk,
  output logic      [7:0]  s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [7:0]  s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end

  // released payloads are inverted so a stale value is never mistaken for live data
  task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {addr, data, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    forever begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~addr};
      if (s_axi_wvalid && s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~data};
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  // read; waits for the answer with no assumed latency
  task automatic axi_read(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge clk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {addr, 2'b11};
    forever begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) {s_axi_arvalid, s_axi_araddr} <= {1'b0, ~addr};
      if (s_axi_rvalid) break;
    end
    {data, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : axi_read

  // both bytes of a field loaded together, ahead of the caption line
  task automatic load_caption(input logic even, input logic [7:0] lo, input logic [7:0] hi);
    logic [1:0] r;
    axi_write(even ? ADDR_CC_EVEN0 : ADDR_CC_ODD0, {24'h0, lo}, r);
    axi_write(even ? ADDR_CC_EVEN1 : ADDR_CC_ODD1, {24'h0, hi}, r);
  endtask : load_caption
endmodule : vcci_host_model

// ### sim/vcci_inserter_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin numChecks++; if ((gt) !== (ex)) begin fails++; $display("MISMATCH %s exp=%h got=%h", nm, ex, gt); end end
// ------
// bench for the inserter
// ------
module vcci_inserter_tb
  import vcci_pkg::*;
  ;
  localparam logic [7:0] HIGH     = 8'h7e;
  localparam int         BIT_CYC  = 10;  // 80 ns bits at 8 ns
  localparam int         LINE_CYC = 400;
  localparam int         TIMEOUT  = 40000;
  localparam logic [15:0] CAPS [3] = '{16'hc241, 16'h2c14, 16'h0000};
  logic        clk, rst, lineStart, oddField, vbiInsert;
  logic [9:0]  lineNumber;
  logic [7:0]  pixelIn, pixelOut, s_axi_awaddr, s_axi_araddr;
  logic [7:0]  cap [0:LINE_CYC-1];
  logic [31:0] s_axi_wdata, s_axi_rdata, rdVal;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          fails, numChecks, cycles;

  vcci_inserter #(.CC_BIT_NS(80), .COPY_BIT_NS(80), .CC_START_NS(800), .COPY_START_NS(800), .BLANK_CODE(8'h10),
    .HIGH_CODE(HIGH)) DUT (.*);
  vcci_host_model host (.*);

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      fails++;
      tally_and_finish();
    end
  end

  // caption symbols: run-in, two blanks, start, bytes lsb first with odd parity
  function automatic logic [25:0] cc_vec(input logic [7:0] lo, input logic [7:0] hi);
    return {~^hi[6:0], hi[6:0], ~^lo[6:0], lo[6:0], 3'b100, 7'h7f};
  endfunction : cc_vec

  // copy symbols: reference pulse then the twenty word bits
  function automatic logic [25:0] copy_vec(input logic [7:0] r0, input logic [7:0] r1, input logic [7:0] r2);
    logic [19:0] c;
    logic [5:0]  s;
    c = {r0[3:0], r1, r2};
    s = CRC_PRESET;
    for (int i = 0; i < 14; i++) s = {s[4:0], 1'b0} ^ ((c[i] ^ s[5]) ? CRC_TAPS : 6'h00);
    if (r0[BIT_CRC_AUTO]) c[19:14] = s;
    return {5'h0, c, 1'b1};
  endfunction : copy_vec

  // one video line; symbols sampled early in each bit, timed from the first high level
  task automatic run_line(input logic [9:0] ln, input logic odd, input logic expIns, input int nsym,
                          input logic [25:0] expV, input int expW);
    int t0;
    int w;
    logic ins;
    logic [25:0] obs;
    t0 = -1;
    w = 0;
    obs = 26'h0;
    {lineNumber, oddField, lineStart} <= {ln, odd, 1'b1};
    @(posedge clk);
    lineStart <= 1'b0;
    for (int i = 0; i < LINE_CYC; i++) begin
      @(posedge clk);
      cap[i] = pixelOut;
      if (i == 20) ins = vbiInsert;
      if (t0 < 0 && i > 1 && cap[i] === HIGH) t0 = i;  // cap[0] may still be a passed pixel
      pixelIn <= pixelIn + 8'h35;
    end
    `CHK("vbiInsert", expIns, ins)
    if (expIns && t0 >= 0) begin
      for (int i = t0; i < LINE_CYC && cap[i] === HIGH; i++) w++;
      for (int k = 0; k < nsym; k++) obs[k] = cap[t0 + k * BIT_CYC + 2] === HIGH;
      `CHK("symbols", expV, obs)
      `CHK("first pulse", expW, w)
    end else if (expIns) begin
      `CHK("waveform start", 1, 0)
    end
  endtask : run_line

  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
    logic [1:0] r;
    host.axi_write(addr, {24'h0, data}, r);
    `CHK("bresp", RESP_OKAY, r)
  endtask : reg_wr

  task automatic tally_and_finish();
    if (fails == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    {rst, lineStart, oddField, lineNumber, pixelIn} = {2'b10, 1'b0, 10'h0, 8'h0};
    {fails, numChecks, cycles} = {32'd0, 32'd0, 32'd0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    host.axi_read(ADDR_CTRL, rdVal, resp);
    `CHK("ctrl reset", {24'h0, CTRL_RESET}, rdVal)
    host.axi_read(8'h24, rdVal, resp);
    `CHK("unmapped rresp", RESP_SLVERR, resp)
    `CHK("unmapped rdata", 32'h0, rdVal)
    host.axi_write(8'h24, 32'h5a, resp);
    `CHK("unmapped bresp", RESP_SLVERR, resp)
    reg_wr(ADDR_COPY0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      host.load_caption(1'b0, CAPS[i][7:0], CAPS[i][15:8]);
      run_line(COPY_ODD_LINE, 1'b1, 1'b0, 0, 26'h0, 0);
      run_line(CC_ODD_LINE, 1'b1, 1'b1, 26, cc_vec(CAPS[i][7:0], CAPS[i][15:8]), 5);
    end
    host.load_caption(1'b1, 8'h55, 8'h80);
    run_line(CC_EVEN_LINE, 1'b0, 1'b1, 26, cc_vec(8'h55, 8'h80), 5);
    run_line(CC_ODD_LINE, 1'b0, 1'b0, 0, 26'h0, 0);
    run_line(10'h016, 1'b1, 1'b0, 0, 26'h0, 0);
    reg_wr(ADDR_COPY2, 8'hb4);
    reg_wr(ADDR_COPY1, 8'h3c);
    reg_wr(ADDR_COPY0, 8'h29);
    run_line(COPY_ODD_LINE, 1'b1, 1'b1, 21, copy_vec(8'h29, 8'h3c, 8'hb4), 10);
    reg_wr(ADDR_COPY0, 8'h56);
    run_line(COPY_EVEN_LINE, 1'b0, 1'b1, 21, copy_vec(8'h56, 8'h3c, 8'hb4), 10);
    run_line(COPY_ODD_LINE, 1'b1, 1'b0, 0, 26'h0, 0);
    reg_wr(ADDR_CTRL, 8'h06);
    run_line(COPY_EVEN_LINE, 1'b0, 1'b0, 0, 26'h0, 0);
    tally_and_finish();
  end
endmodule : vcci_inserter_tb
